/* sbcb_host.sv */
/* Host model that issues register uploads over the serial port.
   Assumes the bench calls frame on a ref clock edge plus 1 ns. */
`timescale 1ns/10ps
module sbcb_host (
  // Serial pins toward the sensor.
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  // Read data from the sensor.
  input wire logic miso_i
);
  // Idle pins: clock parked low, device deselected.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One frame, MSB first: address, direction, data; n below 26 aborts.
  // The 80 ns half period leaves ten ref cycles for edge detection.
  task automatic frame(input logic [8:0] a, input logic wr,
    input logic [15:0] d, input int n, output logic [15:0] q);
    logic [25:0] f;
    f = {a, wr, d};
    q = 16'h0000;
    cs_n_o = 1'b0;
    for (int i = 25; i > 25 - n; i--) begin
      mosi_o = f[i];
      #80 sclk_o = 1'b1;
      q = {q[14:0], miso_i};
      #80 sclk_o = 1'b0;
    end
    // A released data line shows the inverse, never a stale bit.
    mosi_o = ~mosi_o;
    cs_n_o = 1'b1;
    #80;
  endtask
endmodule // sbcb_host

/* sbcb_mem_if.sv */
/*
  Interface between the bring-up logic and its register memory.
  Assumes both ends run on the same reference clock.
*/
`timescale 1ns/10ps
interface sbcb_mem_if;
  logic we; // Write strobe, one cycle.
  logic [8:0] addr; // Word address.
  logic [15:0] wdata; // Write data.
  logic [15:0] rdata; // Registered read data.
  modport user (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

/* sbcb_pkg.sv */
/*
  Shared constants of the sensor clock bring-up block: register offsets,
  reset values, field positions, frame layout, timing and power states.
  Assumes it is compiled before every other file of the block.
*/
package sbcb_pkg;

  // Register offsets, nine-bit register addresses.
  localparam logic [8:0] ADDR_SENSOR_TYPE = 9'h002;
  localparam logic [8:0] ADDR_PLL_SOFT_RST = 9'h008;
  localparam logic [8:0] ADDR_CLKGEN_SOFT_RST = 9'h009;
  localparam logic [8:0] ADDR_PLL_ENABLE = 9'h010;
  localparam logic [8:0] ADDR_PLL_CONFIG = 9'h011;
  localparam logic [8:0] ADDR_CLOCK_INPUT = 9'h014;
  localparam logic [8:0] ADDR_LOCK_CFG_A = 9'h01A;
  localparam logic [8:0] ADDR_LOCK_CFG_B = 9'h01B;
  localparam logic [8:0] ADDR_PLL_STATUS = 9'h018;
  localparam logic [8:0] ADDR_CLOCK_MGMT = 9'h020;
  localparam logic [8:0] ADDR_BLOCK_ENABLE = 9'h022;
  localparam logic [8:0] ADDR_SEQUENCER = 9'h0C0;

  // Reset values: both soft resets start asserted, all enables cleared.
  localparam logic [15:0] RST_SOFT_RESET = 16'h0001;
  localparam logic [15:0] RST_CLEARED = 16'h0000;

  // Field positions.
  localparam int PLL_EN_BIT = 0;
  localparam int PLL_BYPASS_BIT = 2;
  localparam int SOFT_RST_BIT = 0;
  localparam int CLKIN_EN_BIT = 0;
  localparam int LOGIC_CLK_BIT = 1;
  localparam int BLOCK_EN_BIT = 0;
  localparam int SEQ_EN_BIT = 0;
  localparam int SHUTTER_LSB = 1;
  localparam int LOCK_BIT = 0;

  // Serial frame: address bits, direction bit, data bits.
  localparam int ADDR_BITS = 9;
  localparam int DATA_BITS = 16;
  localparam logic [4:0] HDR_LAST = 5'h09;
  localparam logic [4:0] FRAME_LAST = 5'h19;
  localparam int MEM_DEPTH = 512;

  // PLL lock time and its cycle count at the 125 MHz reference clock.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int PLL_LOCK_TIME_NS = 10000;
  localparam logic [15:0] PLL_LOCK_CYCLES =
    16'((PLL_LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // Power states, ordered by dissipation.
  typedef enum logic [2:0] {
    ST_LP_STANDBY,
    ST_STANDBY1,
    ST_STANDBY2,
    ST_IDLE,
    ST_RUNNING
  } sbcb_state_t;

endpackage

/* sbcb_regmem.sv */
/*
  Register memory holding every sensor register word.
  Assumes the user drives address and strobe from flip-flops.
*/
`timescale 1ns/10ps
module sbcb_regmem (
  // Clock and freeze.
  input wire logic ref_clk_i,
  input wire logic ce_i,
  // Memory port.
  sbcb_mem_if.mem port
);

  // Storage is not reset, so contents survive every power state.
  logic [15:0] mem_reg [sbcb_pkg::MEM_DEPTH];

  // Writes land on the strobe; read data always come out of a register.
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (port.we) begin
        mem_reg[port.addr] <= port.wdata;
      end
      port.rdata <= mem_reg[port.addr];
    end
  end

endmodule // sbcb_regmem

/* sbcb_top.sv */
/*
  Power-state and clock bring-up logic of the image sensor, reached over
  its serial register port. Assumes a host that obeys the upload order,
  and a serial clock well below the 125 MHz reference clock.
*/
`timescale 1ns/10ps
module sbcb_top (
  // Clock, reset and freeze.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Serial register port pins.
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  // Clock management and power state.
  output logic pll_enable_o,
  output logic pll_bypass_o,
  output logic lvds_rx_enable_o,
  output logic pll_locked_o,
  output logic logic_clk_enable_o,
  output logic blocks_enable_o,
  output logic sequencer_enable_o,
  output logic [1:0] shutter_mode_o,
  output logic [2:0] power_state_o
);

  sbcb_mem_if mem_bus ();

  // Pin synchronisers: stage one is read only by stage two.
  logic [2:0] pin_s1_reg; // Stage one: sclk, cs_n, mosi.
  logic [2:0] pin_s2_reg; // Stage two, safe to use.
  logic sclk_prev_reg; // Delayed serial clock for edge finding.
  logic sclk_rise; // Serial clock rising edge seen.
  logic sclk_fall; // Serial clock falling edge seen.
  logic cs_n_s; // Synchronised chip select, active low.
  logic mosi_s; // Synchronised serial data in.

  // Frame state.
  logic [4:0] bit_cnt_reg; // Bits received in the current frame.
  logic [15:0] shift_in_reg; // Incoming bits.
  logic [8:0] addr_reg; // Address of the current frame.
  logic is_write_reg; // Frame direction, high for write.
  logic [15:0] shift_out_reg; // Outgoing read data.
  logic rd_pend1_reg; // Read issued to the memory.
  logic rd_pend2_reg; // Read data ready to load.

  // Shadow copies of the registers that steer the logic.
  logic [15:0] type_reg;
  logic [15:0] pll_rst_reg;
  logic [15:0] clkgen_rst_reg;
  logic [15:0] pll_en_reg;
  logic [15:0] clkin_reg;
  logic [15:0] cmcfg_reg;
  logic [15:0] blk_reg;
  logic [15:0] seq_reg;

  // Lock detector and power state.
  logic [15:0] lock_cnt_reg; // Cycles since the PLL started.
  logic locked; // Lock detector satisfied.
  logic pll_run; // PLL started and not bypassed.
  logic clk_run; // A clock source is running.
  logic logic_clk; // Derived logic clock may run.
  sbcb_pkg::sbcb_state_t state_reg;
  sbcb_pkg::sbcb_state_t state_next;
  logic [15:0] rd_value; // Value answered for a read.
  logic accessible; // Current address may be touched.
  logic [15:0] wdata; // Completed write data word.

  assign sclk_rise = pin_s2_reg[0] & ~sclk_prev_reg;
  assign sclk_fall = ~pin_s2_reg[0] & sclk_prev_reg;
  assign cs_n_s = pin_s2_reg[1];
  assign mosi_s = pin_s2_reg[2];
  assign wdata = {shift_in_reg[14:0], mosi_s};

  // Two flip-flops on every pin, then one more on the clock for edges.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_s1_reg <= 3'h2;
      pin_s2_reg <= 3'h2;
      sclk_prev_reg <= 1'b0;
    end else if (ce_i) begin
      pin_s1_reg <= {spi_mosi_i, spi_cs_n_i, spi_sclk_i};
      pin_s2_reg <= pin_s1_reg;
      sclk_prev_reg <= pin_s2_reg[0];
    end
  end

  // Clock, type and block-enable registers stay reachable below standby two; others need it.
  always_comb begin
    accessible = 1'b0;
    if (state_reg != sbcb_pkg::ST_LP_STANDBY &&
        state_reg != sbcb_pkg::ST_STANDBY1) begin
      accessible = 1'b1;
    end else begin
      case (addr_reg)
        sbcb_pkg::ADDR_SENSOR_TYPE, sbcb_pkg::ADDR_PLL_SOFT_RST,
        sbcb_pkg::ADDR_CLKGEN_SOFT_RST, sbcb_pkg::ADDR_PLL_ENABLE,
        sbcb_pkg::ADDR_PLL_CONFIG, sbcb_pkg::ADDR_CLOCK_INPUT,
        sbcb_pkg::ADDR_LOCK_CFG_A, sbcb_pkg::ADDR_LOCK_CFG_B,
        sbcb_pkg::ADDR_PLL_STATUS, sbcb_pkg::ADDR_CLOCK_MGMT,
        sbcb_pkg::ADDR_BLOCK_ENABLE: begin
          accessible = 1'b1;
        end
        default: begin
          accessible = 1'b0;
        end
      endcase
    end
  end

  // Frame receiver: address, direction, then data, most significant first.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bit_cnt_reg <= 5'h00;
      shift_in_reg <= 16'h0000;
      addr_reg <= 9'h000;
      is_write_reg <= 1'b0;
    end else if (ce_i) begin
      if (cs_n_s) begin
        bit_cnt_reg <= 5'h00; // Deselect aborts a partial frame.
      end else if (sclk_rise) begin
        shift_in_reg <= wdata;
        if (bit_cnt_reg != 5'h1F) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        if (bit_cnt_reg == sbcb_pkg::HDR_LAST) begin
          addr_reg <= shift_in_reg[8:0];
          is_write_reg <= mosi_s;
        end
      end
    end
  end

  // Memory strobes: read after the header, write after the last data bit.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mem_bus.we <= 1'b0;
      mem_bus.addr <= 9'h000;
      mem_bus.wdata <= 16'h0000;
      rd_pend1_reg <= 1'b0;
      rd_pend2_reg <= 1'b0;
    end else if (ce_i) begin
      mem_bus.we <= 1'b0;
      rd_pend1_reg <= 1'b0;
      rd_pend2_reg <= rd_pend1_reg;
      if (!cs_n_s && sclk_rise && bit_cnt_reg == sbcb_pkg::HDR_LAST) begin
        mem_bus.addr <= shift_in_reg[8:0];
        rd_pend1_reg <= ~mosi_s;
      end
      if (!cs_n_s && sclk_rise && bit_cnt_reg == sbcb_pkg::FRAME_LAST &&
          is_write_reg && accessible) begin
        mem_bus.we <= 1'b1;
        mem_bus.wdata <= wdata;
      end
    end
  end

  // Steering registers are shadowed so state follows each accepted write.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      type_reg <= sbcb_pkg::RST_CLEARED;
      pll_rst_reg <= sbcb_pkg::RST_SOFT_RESET;
      clkgen_rst_reg <= sbcb_pkg::RST_SOFT_RESET;
      pll_en_reg <= sbcb_pkg::RST_CLEARED;
      clkin_reg <= sbcb_pkg::RST_CLEARED;
      cmcfg_reg <= sbcb_pkg::RST_CLEARED;
      blk_reg <= sbcb_pkg::RST_CLEARED;
      seq_reg <= sbcb_pkg::RST_CLEARED;
    end else if (ce_i && mem_bus.we) begin
      case (mem_bus.addr)
        sbcb_pkg::ADDR_SENSOR_TYPE: type_reg <= mem_bus.wdata;
        sbcb_pkg::ADDR_PLL_SOFT_RST: pll_rst_reg <= mem_bus.wdata;
        sbcb_pkg::ADDR_CLKGEN_SOFT_RST: clkgen_rst_reg <= mem_bus.wdata;
        sbcb_pkg::ADDR_PLL_ENABLE: pll_en_reg <= mem_bus.wdata;
        sbcb_pkg::ADDR_CLOCK_INPUT: clkin_reg <= mem_bus.wdata;
        sbcb_pkg::ADDR_CLOCK_MGMT: cmcfg_reg <= mem_bus.wdata;
        sbcb_pkg::ADDR_BLOCK_ENABLE: blk_reg <= mem_bus.wdata;
        sbcb_pkg::ADDR_SEQUENCER: seq_reg <= mem_bus.wdata;
        default: begin
        end
      endcase
    end
  end

  // Readback: status and shadows come from flops, the rest from memory.
  always_comb begin
    case (addr_reg)
      sbcb_pkg::ADDR_PLL_STATUS: rd_value = {15'h0000, locked};
      sbcb_pkg::ADDR_SENSOR_TYPE: rd_value = type_reg;
      sbcb_pkg::ADDR_PLL_SOFT_RST: rd_value = pll_rst_reg;
      sbcb_pkg::ADDR_CLKGEN_SOFT_RST: rd_value = clkgen_rst_reg;
      sbcb_pkg::ADDR_PLL_ENABLE: rd_value = pll_en_reg;
      sbcb_pkg::ADDR_CLOCK_INPUT: rd_value = clkin_reg;
      sbcb_pkg::ADDR_CLOCK_MGMT: rd_value = cmcfg_reg;
      sbcb_pkg::ADDR_BLOCK_ENABLE: rd_value = blk_reg;
      sbcb_pkg::ADDR_SEQUENCER: rd_value = seq_reg;
      default: rd_value = mem_bus.rdata;
    endcase
    if (!accessible) begin
      rd_value = 16'h0000;
    end
  end

  // Read data shift out on falling serial clock edges after the header.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      shift_out_reg <= 16'h0000;
      spi_miso_o <= 1'b0;
    end else if (ce_i) begin
      if (rd_pend2_reg) begin
        shift_out_reg <= rd_value;
      end else if (cs_n_s) begin
        spi_miso_o <= 1'b0;
      end else if (sclk_fall && !is_write_reg &&
                   bit_cnt_reg > sbcb_pkg::HDR_LAST) begin
        spi_miso_o <= shift_out_reg[15];
        shift_out_reg <= {shift_out_reg[14:0], 1'b0};
      end
    end
  end

  // PLL starts once enabled, not bypassed and out of soft reset.
  assign pll_run = pll_en_reg[sbcb_pkg::PLL_EN_BIT] &
                   ~pll_en_reg[sbcb_pkg::PLL_BYPASS_BIT] &
                   ~pll_rst_reg[sbcb_pkg::SOFT_RST_BIT];
  assign locked = lock_cnt_reg == sbcb_pkg::PLL_LOCK_CYCLES;

  // Lock detector: a stable clock is declared after the lock time.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      lock_cnt_reg <= 16'h0000;
    end else if (ce_i) begin
      if (!pll_run) begin
        lock_cnt_reg <= 16'h0000;
      end else if (!locked) begin
        lock_cnt_reg <= lock_cnt_reg + 16'h0001;
      end
    end
  end

  // Clock sources and derived enables decide the power state.
  assign clk_run = pll_en_reg[sbcb_pkg::PLL_EN_BIT] |
                   clkin_reg[sbcb_pkg::CLKIN_EN_BIT];
  assign logic_clk = clk_run & ~clkgen_rst_reg[sbcb_pkg::SOFT_RST_BIT] &
                     cmcfg_reg[sbcb_pkg::LOGIC_CLK_BIT] &
                     (locked | ~pll_run);

  always_comb begin
    if (logic_clk && blk_reg[sbcb_pkg::BLOCK_EN_BIT] &&
        seq_reg[sbcb_pkg::SEQ_EN_BIT]) begin
      state_next = sbcb_pkg::ST_RUNNING;
    end else if (logic_clk && blk_reg[sbcb_pkg::BLOCK_EN_BIT]) begin
      state_next = sbcb_pkg::ST_IDLE;
    end else if (logic_clk) begin
      state_next = sbcb_pkg::ST_STANDBY2;
    end else if (clk_run) begin
      state_next = sbcb_pkg::ST_STANDBY1;
    end else begin
      state_next = sbcb_pkg::ST_LP_STANDBY;
    end
  end

  // Registered outputs follow the state; low standby drives all enables off.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= sbcb_pkg::ST_LP_STANDBY;
      pll_enable_o <= 1'b0;
      pll_bypass_o <= 1'b0;
      lvds_rx_enable_o <= 1'b0;
      pll_locked_o <= 1'b0;
      logic_clk_enable_o <= 1'b0;
      blocks_enable_o <= 1'b0;
      sequencer_enable_o <= 1'b0;
      shutter_mode_o <= 2'h0;
    end else if (ce_i) begin
      state_reg <= state_next;
      pll_enable_o <= pll_run;
      pll_bypass_o <= pll_en_reg[sbcb_pkg::PLL_EN_BIT] &
                      pll_en_reg[sbcb_pkg::PLL_BYPASS_BIT];
      lvds_rx_enable_o <= clkin_reg[sbcb_pkg::CLKIN_EN_BIT];
      pll_locked_o <= locked;
      logic_clk_enable_o <= logic_clk;
      blocks_enable_o <= state_next == sbcb_pkg::ST_IDLE ||
                         state_next == sbcb_pkg::ST_RUNNING;
      sequencer_enable_o <= state_next == sbcb_pkg::ST_RUNNING;
      shutter_mode_o <= seq_reg[sbcb_pkg::SHUTTER_LSB +: 2];
    end
  end

  assign power_state_o = state_reg;

  sbcb_regmem u_regmem (
    .ref_clk_i(ref_clk_i),
    .ce_i(ce_i),
    .port(mem_bus.mem)
  );

endmodule // sbcb_top

/* sbcb_top_asserts.sv */
/* Power state and clock checks on the ports of sbcb_top.
   Assumes one ref clock domain and the bind at the foot. */
`timescale 1ns/10ps
module sbcb_top_asserts (
  // Clock, reset and freeze.
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Serial port.
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_o,
  // State outputs.
  input wire logic pll_enable_o,
  input wire logic pll_bypass_o,
  input wire logic lvds_rx_enable_o,
  input wire logic pll_locked_o,
  input wire logic logic_clk_enable_o,
  input wire logic blocks_enable_o,
  input wire logic sequencer_enable_o,
  input wire logic [2:0] power_state_o
);
  // Lock must follow 1250 running cycles, give or take the pipeline.
  localparam int LOCK_MIN = 1247;
  localparam int LOCK_MAX = 1253;
  logic [15:0] en_cnt_reg; // Cycles the PLL has run unbroken.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Count enabled cycles, restarting whenever the PLL stops.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !pll_enable_o) begin
      en_cnt_reg <= 16'h0000;
    end else if (ce_i && en_cnt_reg != 16'hFFFF) begin
      en_cnt_reg <= en_cnt_reg + 16'h0001;
    end
  end
  property p_lp_off;
    power_state_o == 3'h0 |-> !(pll_enable_o | lvds_rx_enable_o |
      logic_clk_enable_o | blocks_enable_o | sequencer_enable_o);
  endproperty
  a_lp_off: assert property (p_lp_off)
    else $error("low standby active");
  property p_sb1;
    power_state_o == 3'h1 |-> !logic_clk_enable_o &&
      (pll_enable_o || pll_bypass_o || lvds_rx_enable_o);
  endproperty
  a_sb1: assert property (p_sb1) else $error("standby one clocks");
  property p_sb2;
    power_state_o == 3'h2 |-> logic_clk_enable_o && !blocks_enable_o;
  endproperty
  a_sb2: assert property (p_sb2) else $error("standby two clocks");
  property p_idle;
    power_state_o == 3'h3 |-> blocks_enable_o && !sequencer_enable_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle enables");
  property p_run;
    sequencer_enable_o |-> power_state_o == 3'h4 && blocks_enable_o;
  endproperty
  a_run: assert property (p_run) else $error("running enables");
  property p_bypass;
    pll_bypass_o |-> !pll_enable_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass runs PLL");
  property p_lock_early;
    $rose(pll_locked_o) |-> en_cnt_reg >= LOCK_MIN;
  endproperty
  a_lock_early: assert property (p_lock_early)
    else $error("lock early");
  property p_lock_late;
    en_cnt_reg == LOCK_MAX |-> pll_locked_o;
  endproperty
  a_lock_late: assert property (p_lock_late) else $error("lock late");
  property p_miso_idle;
    spi_cs_n_i [*6] |-> !spi_miso_o;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso busy");
  c_run: cover property (power_state_o == 3'h4);
  c_lock: cover property ($rose(pll_locked_o));
  c_bypass: cover property (pll_bypass_o && logic_clk_enable_o);
endmodule // sbcb_top_asserts
bind sbcb_top sbcb_top_asserts i_asserts (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .ce_i(ce_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_miso_o(spi_miso_o), .pll_enable_o(pll_enable_o),
  .pll_bypass_o(pll_bypass_o), .lvds_rx_enable_o(lvds_rx_enable_o),
  .pll_locked_o(pll_locked_o), .logic_clk_enable_o(logic_clk_enable_o),
  .blocks_enable_o(blocks_enable_o),
  .sequencer_enable_o(sequencer_enable_o), .power_state_o(power_state_o));

/* sbcb_top_tb.sv */
/* Self-checking bench of sbcb_top driving uploads through sbcb_host.
   Assumes the package, design, host model and checker are compiled. */
`timescale 1ns/10ps
module sbcb_top_tb;
  // Pins of the design.
  logic ref_clk_i, reset_i, spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o;
  logic pll_enable_o, pll_bypass_o, lvds_rx_enable_o, pll_locked_o;
  logic logic_clk_enable_o, blocks_enable_o, sequencer_enable_o;
  logic [1:0] shutter_mode_o;
  logic [2:0] power_state_o;
  logic [15:0] q; // Last word read back.
  logic ce_i = 1'b1; // Freeze control, high to run.
  int num_errors = 0;
  int check_count = 0;
  // All state outputs packed, from PLL enable down to the state code.
  wire logic [11:0] pins = {pll_enable_o, pll_bypass_o, lvds_rx_enable_o,
    pll_locked_o, logic_clk_enable_o, blocks_enable_o, sequencer_enable_o,
    shutter_mode_o, power_state_o};
  sbcb_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o),
    .pll_enable_o(pll_enable_o), .pll_bypass_o(pll_bypass_o),
    .lvds_rx_enable_o(lvds_rx_enable_o), .pll_locked_o(pll_locked_o),
    .logic_clk_enable_o(logic_clk_enable_o),
    .blocks_enable_o(blocks_enable_o),
    .sequencer_enable_o(sequencer_enable_o),
    .shutter_mode_o(shutter_mode_o), .power_state_o(power_state_o));
  sbcb_host i_host (.sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i),
    .mosi_o(spi_mosi_i), .miso_i(spi_miso_o));
  // 125 MHz reference clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Compares one register word.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Compares the packed state outputs.
  task automatic chk_pin(input logic [11:0] exp);
    check_count++;
    if (pins !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, pins, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Register write and checked read over the serial port.
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    i_host.frame(a, 1'b1, d, 26, q);
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    i_host.frame(a, 1'b0, 16'h0000, 26, q);
    chk(q, e);
  endtask
  // Polls the lock flag a bounded number of times, then checks it.
  task automatic poll_lock();
    q = 16'h0000;
    for (int k = 0; k < 10 && q[0] !== 1'b1; k++) begin
      i_host.frame(sbcb_pkg::ADDR_PLL_STATUS, 1'b0, 16'h0000, 26, q);
    end
    chk(q & 16'h0001, 16'h0001);
  endtask
  // Three-cycle reset, then the settling wait before the first frame.
  task automatic rst();
    @(posedge ref_clk_i);
    #1 reset_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    chk_pin(12'h000);
    repeat (1250) @(posedge ref_clk_i);
    #1;
  endtask
  // Main sequence: parallel bypass, 8-bit PLL, a second PLL run, then 10-bit without PLL.
  initial begin
    reset_i = 1'b1;
    rst();
    rd(sbcb_pkg::ADDR_PLL_SOFT_RST, sbcb_pkg::RST_SOFT_RESET);
    rd(sbcb_pkg::ADDR_CLKGEN_SOFT_RST, sbcb_pkg::RST_SOFT_RESET);
    wr(sbcb_pkg::ADDR_SEQUENCER, 16'h0001);
    chk_pin(12'h000);
    rd(sbcb_pkg::ADDR_SEQUENCER, 16'h0000);
    wr(sbcb_pkg::ADDR_SENSOR_TYPE, 16'h0003);
    // An aborted frame must leave the word untouched.
    i_host.frame(sbcb_pkg::ADDR_SENSOR_TYPE, 1'b1, 16'h0002, 20, q);
    rd(sbcb_pkg::ADDR_SENSOR_TYPE, 16'h0003);
    wr(sbcb_pkg::ADDR_CLOCK_MGMT, 16'h200C);
    wr(sbcb_pkg::ADDR_CLOCK_INPUT, 16'h0000);
    wr(sbcb_pkg::ADDR_PLL_ENABLE, 16'h0007);
    chk_pin(12'h401);
    wr(sbcb_pkg::ADDR_CLKGEN_SOFT_RST, 16'h0000);
    wr(sbcb_pkg::ADDR_CLOCK_MGMT, 16'h200E);
    chk_pin(12'h482);
    wr(sbcb_pkg::ADDR_SEQUENCER, 16'h0004);
    rd(sbcb_pkg::ADDR_SEQUENCER, 16'h0004);
    wr(sbcb_pkg::ADDR_BLOCK_ENABLE, 16'h0001);
    chk_pin(12'h4D3);
    wr(sbcb_pkg::ADDR_SEQUENCER, 16'h0005);
    chk_pin(12'h4F4);
    rst();
    wr(sbcb_pkg::ADDR_SENSOR_TYPE, 16'h0000);
    wr(sbcb_pkg::ADDR_CLOCK_MGMT, 16'h200C);
    wr(sbcb_pkg::ADDR_CLOCK_INPUT, 16'h0000);
    wr(sbcb_pkg::ADDR_PLL_CONFIG, 16'h210F);
    wr(sbcb_pkg::ADDR_LOCK_CFG_A, 16'h1180);
    wr(sbcb_pkg::ADDR_LOCK_CFG_B, 16'hCCBC);
    wr(sbcb_pkg::ADDR_PLL_SOFT_RST, 16'h0000);
    wr(sbcb_pkg::ADDR_PLL_ENABLE, 16'h0003);
    chk_pin(12'h801);
    poll_lock();
    chk_pin(12'h901);
    // Plain words live in the memory, so this reads the memory path.
    rd(sbcb_pkg::ADDR_PLL_CONFIG, 16'h210F);
    wr(sbcb_pkg::ADDR_CLKGEN_SOFT_RST, 16'h0000);
    wr(sbcb_pkg::ADDR_CLOCK_MGMT, 16'h200E);
    wr(sbcb_pkg::ADDR_BLOCK_ENABLE, 16'h0001);
    chk_pin(12'h9C3);
    rst();
    wr(sbcb_pkg::ADDR_SENSOR_TYPE, 16'h0000);
    wr(sbcb_pkg::ADDR_CLOCK_MGMT, 16'h2004);
    wr(sbcb_pkg::ADDR_CLOCK_INPUT, 16'h0000);
    wr(sbcb_pkg::ADDR_PLL_CONFIG, 16'h2113);
    wr(sbcb_pkg::ADDR_LOCK_CFG_A, 16'h2280);
    wr(sbcb_pkg::ADDR_LOCK_CFG_B, 16'h3D2D);
    wr(sbcb_pkg::ADDR_PLL_SOFT_RST, 16'h0000);
    wr(sbcb_pkg::ADDR_PLL_ENABLE, 16'h0003);
    chk_pin(12'h801);
    poll_lock();
    // Memory survives reset, so the new word must replace the old one.
    rd(sbcb_pkg::ADDR_LOCK_CFG_A, 16'h2280);
    wr(sbcb_pkg::ADDR_CLKGEN_SOFT_RST, 16'h0000);
    wr(sbcb_pkg::ADDR_CLOCK_MGMT, 16'h2006);
    wr(sbcb_pkg::ADDR_BLOCK_ENABLE, 16'h0001);
    chk_pin(12'h9C3);
    rst();
    wr(sbcb_pkg::ADDR_SENSOR_TYPE, 16'h0001);
    wr(sbcb_pkg::ADDR_CLOCK_MGMT, 16'h2000);
    wr(sbcb_pkg::ADDR_CLOCK_INPUT, 16'h0001);
    chk_pin(12'h201);
    wr(sbcb_pkg::ADDR_CLKGEN_SOFT_RST, 16'h0000);
    wr(sbcb_pkg::ADDR_CLOCK_MGMT, 16'h2002);
    wr(sbcb_pkg::ADDR_BLOCK_ENABLE, 16'h0001);
    chk_pin(12'h2C3);
    // While frozen, a whole write frame must pass unseen.
    ce_i = 1'b0;
    wr(sbcb_pkg::ADDR_SEQUENCER, 16'h0001);
    chk_pin(12'h2C3);
    ce_i = 1'b1;
    rd(sbcb_pkg::ADDR_SEQUENCER, 16'h0000);
    end_of_test();
  end
  // Watchdog: the uploads need about 270 us; 500 us means a hang.
  initial begin
    #500000;
    num_errors++;
    end_of_test();
  end
endmodule // sbcb_top_tb
